/* File: core/csmc_top.v */
// AXI4-Lite configuration slave for clock source, divider, PLL power and oscillator calibration.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "csmc_regs.vh"
module csmc_top (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Active settings toward the analog sections
    output reg pll_enable,
    output reg pll_async_powerdown,
    output reg internal_oscillator_select,
    output reg divider_bypass,
    output reg [2:0] divider_setting,
    output reg phase_detector_negative,
    output reg [2:0] ref_enable,
    output reg cal_start,
    output reg cal_clear
);
    // ----------------------------------------------------------------
    // Staged and active state
    // ----------------------------------------------------------------
    reg [7:0] stg_pll;
    reg stg_cal;
    reg [2:0] stg_ref;
    reg [2:0] stg_div;
    reg [1:0] stg_src;
    reg [7:0] act_pll;
    reg act_cal;
    reg [2:0] act_ref;
    reg [2:0] act_div;
    reg [1:0] act_src;
    reg update;
    // Saved copy; it survives aresetn and is what reset restores.
    reg [7:0] nv_pll;
    reg [2:0] nv_ref;
    reg [2:0] nv_div;
    reg [1:0] nv_src;
    reg nv_valid;
    reg aw_held;
    reg w_held;
    reg [9:0] aw_idx;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire do_write = aw_held && w_held;
    wire [31:0] wd = w_data;
    wire b0 = w_strb[0];
    wire wr_pll = do_write && aw_idx == `CSMC_IDX_PLL_CTRL;
    wire wr_cal = do_write && aw_idx == `CSMC_IDX_CAL_CTRL;
    wire wr_ref = do_write && aw_idx == `CSMC_IDX_REF_CTRL;
    wire wr_div = do_write && aw_idx == `CSMC_IDX_DIV_CTRL;
    wire wr_src = do_write && aw_idx == `CSMC_IDX_SRC_CTRL;
    wire wr_upd = do_write && aw_idx == `CSMC_IDX_UPDATE;
    wire wr_nvm = do_write && aw_idx == `CSMC_IDX_NVM;
    wire wr_ok = wr_pll || wr_cal || wr_ref || wr_div || wr_src || wr_upd || wr_nvm;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 10'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSMC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_idx <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `CSMC_RESP_OKAY : `CSMC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Staging, update and saved copy
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            // Saved settings win over the defaults when present.
            stg_pll <= nv_valid ? nv_pll : `CSMC_RST_PLL;
            act_pll <= nv_valid ? nv_pll : `CSMC_RST_PLL;
            stg_ref <= nv_valid ? nv_ref : `CSMC_RST_REF;
            act_ref <= nv_valid ? nv_ref : `CSMC_RST_REF;
            stg_div <= nv_valid ? nv_div : `CSMC_RST_DIV;
            act_div <= nv_valid ? nv_div : `CSMC_RST_DIV;
            stg_src <= nv_valid ? nv_src : `CSMC_RST_SRC;
            act_src <= nv_valid ? nv_src : `CSMC_RST_SRC;
            stg_cal <= `CSMC_RST_CAL;
            act_cal <= `CSMC_RST_CAL;
            update <= 1'b0;
            cal_start <= 1'b0;
            cal_clear <= 1'b0;
        end else begin
            if (wr_pll && b0) stg_pll <= wd[`CSMC_PLL_MSB:`CSMC_FIELD_LSB];
            if (wr_cal && b0) stg_cal <= wd[`CSMC_CAL_BIT];
            if (wr_ref && b0) stg_ref <= wd[`CSMC_REF_MSB:`CSMC_FIELD_LSB];
            if (wr_div && b0) stg_div <= wd[`CSMC_DIV_MSB:`CSMC_FIELD_LSB];
            if (wr_src && b0) stg_src <= wd[`CSMC_SEL_BIT:`CSMC_BYP_BIT];
            // The strobe is taken one cycle, then applied and cleared together on the next.
            update <= wr_upd && b0 && wd[`CSMC_UPD_BIT];
            cal_start <= 1'b0;
            cal_clear <= 1'b0;
            if (update) begin
                act_pll <= stg_pll;
                act_ref <= stg_ref;
                act_div <= stg_div;
                act_src <= stg_src;
                act_cal <= stg_cal;
                cal_start <= stg_cal && !act_cal;
                cal_clear <= !stg_cal && act_cal;
            end
        end
    end

    // Nonvolatile copy has no reset by design: it models the stored image.
    initial nv_valid = 1'b0;
    always @(posedge aclk) begin
        if (aresetn && wr_nvm && b0 && wd[`CSMC_NVM_SAVE_BIT]) begin
            nv_pll <= act_pll;
            nv_ref <= act_ref;
            nv_div <= act_div;
            nv_src <= act_src;
            nv_valid <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Active outputs
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            pll_enable <= 1'b0;
            pll_async_powerdown <= 1'b1;
            internal_oscillator_select <= 1'b0;
            divider_bypass <= 1'b0;
            divider_setting <= `CSMC_RST_DIV;
            phase_detector_negative <= 1'b0;
            ref_enable <= `CSMC_RST_REF;
        end else begin
            pll_enable <= act_pll[`CSMC_PWR_MSB:`CSMC_PWR_LSB] == `CSMC_PWR_NORMAL;
            pll_async_powerdown <= act_pll[`CSMC_PWR_MSB:`CSMC_PWR_LSB] == `CSMC_PWR_DOWN;
            internal_oscillator_select <= act_src[`CSMC_SEL_BIT];
            divider_bypass <= act_src[`CSMC_BYP_BIT];
            divider_setting <= act_div;
            // Internal oscillator path uses a fixed positive polarity.
            phase_detector_negative <= act_pll[`CSMC_POL_BIT] && !act_src[`CSMC_SEL_BIT];
            ref_enable <= act_ref;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    wire [9:0] ra = s_axi_araddr[11:2];
    reg [31:0] rd;
    reg rd_ok;
    always @* begin
        rd = 32'h00000000;
        rd_ok = 1'b1;
        case (ra)
            `CSMC_IDX_PLL_CTRL: rd = {24'h0, stg_pll};
            `CSMC_IDX_CAL_CTRL: rd = {31'h0, stg_cal};
            `CSMC_IDX_REF_CTRL: rd = {29'h0, stg_ref};
            `CSMC_IDX_DIV_CTRL: rd = {29'h0, stg_div};
            `CSMC_IDX_SRC_CTRL: rd = {30'h0, stg_src};
            `CSMC_IDX_UPDATE: rd = {31'h0, update};
            `CSMC_IDX_STATUS: rd = {16'h0, act_src, 3'h0, act_div, act_pll};
            `CSMC_IDX_NVM: rd = {30'h0, nv_valid, 1'b0};
            default: rd_ok = 1'b0;
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CSMC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd;
            s_axi_rresp <= rd_ok ? `CSMC_RESP_OKAY : `CSMC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // csmc_top
`default_nettype wire

/* File: core/csmc_regs.vh */
// Register offsets, field positions and reset values of the clock source mode block.
`ifndef CSMC_REGS_VH
`define CSMC_REGS_VH
// Register indices. Three of the offsets are not word aligned, so every register
// sits on a word of its own and its byte address is four times its index.
`define CSMC_IDX_PLL_CTRL 10'h010
`define CSMC_IDX_CAL_CTRL 10'h018
`define CSMC_IDX_REF_CTRL 10'h01c
`define CSMC_IDX_DIV_CTRL 10'h1e0
`define CSMC_IDX_SRC_CTRL 10'h1e1
`define CSMC_IDX_UPDATE 10'h232
`define CSMC_IDX_STATUS 10'h300
`define CSMC_IDX_NVM 10'h301
`define CSMC_PWR_NORMAL 2'h0
`define CSMC_PWR_DOWN 2'h1
`define CSMC_RST_PLL 8'h01
`define CSMC_RST_CAL 1'h0
`define CSMC_RST_REF 3'h0
`define CSMC_RST_DIV 3'h0
`define CSMC_RST_SRC 2'h0
`define CSMC_FIELD_LSB 0
`define CSMC_PWR_MSB 1
`define CSMC_PWR_LSB 0
`define CSMC_POL_BIT 7
`define CSMC_PLL_MSB 7
`define CSMC_CAL_BIT 0
`define CSMC_REF_MSB 2
`define CSMC_DIV_MSB 2
`define CSMC_SEL_BIT 1
`define CSMC_BYP_BIT 0
`define CSMC_UPD_BIT 0
`define CSMC_NVM_SAVE_BIT 0
`define CSMC_NVM_VALID_BIT 1
`define CSMC_RESP_OKAY 2'h0
`define CSMC_RESP_SLVERR 2'h2
`endif

/* File: core/csmc_note_unused.v */
// No logic here; the whole block lives in csmc_top.v.

/* File: verification/csmc_asserts.sv */
// Concurrent checks on the port behaviour of the clock source mode block.
`timescale 1ns/1ps
`default_nettype none
module csmc_asserts (
    // Clock, reset and bus
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Active settings
    input wire logic pll_enable,
    input wire logic pll_async_powerdown,
    input wire logic internal_oscillator_select,
    input wire logic phase_detector_negative,
    input wire logic divider_bypass,
    input wire logic cal_start,
    input wire logic cal_clear
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Settings may only move a few cycles after a write answer, since only the
    // update strobe, itself a write, copies staged values to the outputs.
    logic [2:0] quiet;
    always @(posedge aclk) begin
        if (!aresetn || s_axi_bvalid)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    sequence s_start_once; cal_start ##1 !cal_start; endsequence
    sequence s_clear_once; cal_clear ##1 !cal_clear; endsequence
    a_pll_mode_excl: assert property (!(pll_enable && pll_async_powerdown))
        else $error("PLL run and power-down together");
    a_pol_forced: assert property (internal_oscillator_select |-> !phase_detector_negative)
        else $error("Polarity not fixed with internal oscillator");
    a_cal_pulse: assert property (cal_start |-> s_start_once)
        else $error("Calibration start wider than one cycle");
    a_clr_pulse: assert property (cal_clear |-> s_clear_once)
        else $error("Calibration clear wider than one cycle");
    a_cal_excl: assert property (!(cal_start && cal_clear))
        else $error("Calibration start and clear together");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("Read answer dropped before rready");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("Write address taken while response pending");
    a_cfg_quiet: assert property (quiet > 3'h4 |-> $stable({pll_enable,
        pll_async_powerdown, internal_oscillator_select, divider_bypass}))
        else $error("Settings moved without an update");
endmodule // csmc_asserts
bind csmc_top csmc_asserts u_chk (.*);
`default_nettype wire

/* File: verification/csmc_top_tb.sv */
// Self-checking testbench for the clock source mode block.
`timescale 1ns/1ps
`default_nettype none
module csmc_top_tb;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] divider_setting, ref_enable;
    wire pll_enable, pll_async_powerdown, internal_oscillator_select, divider_bypass;
    wire phase_detector_negative, cal_start, cal_clear;
    // Packed as {run, down, internal, bypass, divider, negative, refs}.
    wire [10:0] outs = {pll_enable, pll_async_powerdown, internal_oscillator_select,
        divider_bypass, divider_setting, phase_detector_negative, ref_enable};
    int failures = 0, compares = 0, n_start = 0, n_clear = 0;
    // Byte address of each register: four times its index.
    localparam logic [11:0] addr_pll = 12'h040, addr_cal = 12'h060, addr_ref = 12'h070;
    localparam logic [11:0] addr_div = 12'h780, addr_src = 12'h784, addr_upd = 12'h8c8;
    localparam logic [11:0] addr_stat = 12'hc00, addr_nvm = 12'hc04;
    csmc_top dut (.*);
    initial begin
        forever #50 aclk = ~aclk;
    end
    // Calibration commands last one cycle, so they are counted as they pass.
    always @(posedge aclk) begin
        n_start <= n_start + (cal_start === 1'b1);
        n_clear <= n_clear + (cal_clear === 1'b1);
    end
    initial begin
        #1000000;
        failures++;
        wrap_up();
    end
    function automatic void chk(string name, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (exp !== got) begin
            failures++;
            $display("Error %s: expected %h, seen %h", name, exp, got);
        end
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] resp;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
        chk("bresp", er, resp);
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(negedge aclk);
        d = s_axi_rdata;
        chk("rresp", er, s_axi_rresp);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic upd;
        wr(addr_upd, 32'h1, 4'h1, 2'h0);
        repeat (3) @(negedge aclk);
    endtask
    task automatic t_stage;
        logic [31:0] d;
        @(negedge aclk);
        chk("reset outputs", 11'h200, outs);
        wr(addr_pll, 32'h0, 4'hf, 2'h0);
        repeat (4) @(negedge aclk);
        chk("staged outputs", 11'h200, outs);
        upd();
        chk("run outputs", 11'h400, outs);
        rd(addr_upd, 2'h0, d);
        chk("strobe", 1'b0, d[0]);
    endtask
    task automatic t_modes;
        logic [31:0] d;
        wr(addr_pll, 32'h81, 4'hf, 2'h0);
        wr(addr_ref, 32'h5, 4'hf, 2'h0);
        wr(addr_div, 32'h5, 4'hf, 2'h0);
        // The external clock of this scenario is taken to be below 1600 MHz.
        wr(addr_src, 32'h1, 4'hf, 2'h0);
        upd();
        chk("external outputs", 11'h2dd, outs);
        wr(addr_div, 32'h3, 4'hf, 2'h0);
        wr(addr_src, 32'h2, 4'hf, 2'h0);
        upd();
        chk("internal outputs", 11'h335, outs);
        rd(addr_src, 2'h0, d);
        chk("source field", 32'h2, d);
        rd(addr_div, 2'h0, d);
        chk("divider field", 32'h3, d);
        rd(addr_stat, 2'h0, d);
        chk("active status", 32'h8381, d);
    endtask
    task automatic t_cal;
        wr(addr_cal, 32'h1, 4'hf, 2'h0);
        upd();
        chk("cal pulses", 8'h10, {n_start[3:0], n_clear[3:0]});
        wr(addr_cal, 32'h0, 4'hf, 2'h0);
        upd();
        chk("cal pulses", 8'h11, {n_start[3:0], n_clear[3:0]});
        wr(addr_cal, 32'h1, 4'hf, 2'h0);
        upd();
        chk("cal pulses", 8'h21, {n_start[3:0], n_clear[3:0]});
    endtask
    task automatic t_unmapped;
        logic [31:0] d;
        wr(12'h100, 32'hffff_ffff, 4'hf, 2'h2);
        rd(12'h100, 2'h2, d);
        chk("unmapped data", 32'h0, d);
    endtask
    task automatic t_saved;
        logic [31:0] d;
        wr(addr_nvm, 32'h1, 4'hf, 2'h0);
        rd(addr_nvm, 2'h0, d);
        chk("saved flag", 1'b1, d[1]);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("reset outputs", 11'h200, outs);
        @(negedge aclk);
        chk("restored outputs", 11'h335, outs);
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_stage();
        t_modes();
        t_cal();
        t_unmapped();
        t_saved();
        wrap_up();
    end
endmodule // csmc_top_tb
`default_nettype wire
